/* File: rtl/pss_sram_port.sv */
// Purpose: Control, burst and data-pin logic of a pipelined synchronous burst SRAM.
// Assumes: Synchronous pins come from logic on clk_in; sleep and the strap are synchronised here.
// Notes:   Output enable acts on the pin drivers directly, as it is an asynchronous control.
// Summary of operation
// - First select, active low, joins select decode.
// - Second select active high; all three must agree.
// - Absent third select counts as always asserted.
// - Selects only matter on address-loading edges.
// - Processor strobe ignored while first select high.
// - Output enable low drives pins, high releases.
// - First read cycle after deselect stays tri-stated.
// - Burst step input advances the burst address.
// - Strobe loads address, keeps low bits as burst start, clears counter.
// - Both strobes low with first select low means processor strobe access.
// - Sleep input stops accesses, keeps the contents.
// - Input data captured on the rising edge.
// - Read data follow their address by one edge.
// - Strap selects linear or interleaved burst order.
// - Global write writes every byte lane.
// - Lane written when its select and gate low.
`timescale 1ns/10ps
module pss_sram_port
#(
   parameter bit THIRD_SELECT_PRESENT = 1'b1
)
(
   input  wire logic                       clk_in,
   input  wire logic                       reset_in,
   input  wire logic [pss_pkg::ADDR_W-1:0] addr_in,
   input  wire logic                       cpu_addr_strobe_n_in,
   input  wire logic                       ctrl_addr_strobe_n_in,
   input  wire logic                       select_low_first_n_in,
   input  wire logic                       select_high_second_in,
   input  wire logic                       select_low_third_n_in,
   input  wire logic                       burst_step_n_in,
   input  wire logic                       write_all_bytes_n_in,
   input  wire logic                       byte_write_gate_n_in,
   input  wire logic [pss_pkg::LANES-1:0]  byte_lane_sel_n_in,
   input  wire logic                       output_enable_n_in,
   input  wire logic                       sleep_request_in,
   input  wire logic                       burst_order_in,
   input  wire logic [pss_pkg::DATA_W-1:0] data_in,
   input  wire logic [pss_pkg::PAR_W-1:0]  parity_pins_in,
   output wire logic [pss_pkg::DATA_W-1:0] data_out,
   output wire logic                       data_oe_n_out,
   output wire logic [pss_pkg::PAR_W-1:0]  parity_pins_out,
   output wire logic                       parity_oe_n_out,
   output wire logic                       sleeping_out
);
   import pss_pkg::*;

   typedef struct packed {
      pss_state_t                state;
      logic [ADDR_W-1:0]         addr_r;
      logic [BURST_W-1:0]        start_r;
      logic [BURST_W-1:0]        cnt_r;
      logic                      read_pend_r;
      logic                      drive_r;
      logic                      emerge_r;
      logic                      sleep_s1;
      logic                      sleep_s2;
      logic                      mode_s1;
      logic                      mode_s2;
      logic [DATA_W+PAR_W-1:0]   dout_r;
   } pss_port_st_t;

   localparam pss_port_st_t ST_RESET = '{state: PSS_IDLE, mode_s1: 1'h1, mode_s2: 1'h1, default: '0};

   pss_port_st_t st;
   pss_port_st_t st_nxt;
   logic         awake;
   logic         cpu_acc;
   logic         ctrl_acc;
   logic         load_c;
   logic         sel_c;
   logic         release_c;
   logic [LANES-1:0] lanes_c;
   pss_mem_if    mif ();

   // Burst order: linear adds the count, interleaved folds it into the start bits.
   function automatic logic [BURST_W-1:0] burst_low(input logic [BURST_W-1:0] start,
                                                    input logic [BURST_W-1:0] cnt,
                                                    input logic               mode);
      if (mode == MODE_LINEAR)
      begin
         burst_low = BURST_W'(start + cnt);
      end
      else
      begin
         burst_low = start ^ cnt;
      end
   endfunction : burst_low

   pss_mem_array u_array
   (
      .clk_in (clk_in),
      .mif    (mif.mem)
   );

   always_comb
   begin
      awake = ~st.sleep_s2;
      cpu_acc = ~cpu_addr_strobe_n_in & ~select_low_first_n_in;
      ctrl_acc = ~ctrl_addr_strobe_n_in & ~cpu_acc;
      // The wake-up cycle still sits in the sleep state, so a strobe there must not count as a load.
      load_c = (cpu_acc | ctrl_acc) & awake & (st.state != PSS_SLEEP);
      sel_c = ~select_low_first_n_in & select_high_second_in &
              (~THIRD_SELECT_PRESENT | ~select_low_third_n_in);
      if (~write_all_bytes_n_in)
      begin
         lanes_c = LANES_ALL;
      end
      else if (~byte_write_gate_n_in)
      begin
         lanes_c = ~byte_lane_sel_n_in;
      end
      else
      begin
         lanes_c = LANES_NONE;
      end

      st_nxt             = st;
      st_nxt.sleep_s1    = sleep_request_in;
      st_nxt.sleep_s2    = st.sleep_s1;
      st_nxt.mode_s1     = burst_order_in;
      st_nxt.mode_s2     = st.mode_s1;
      st_nxt.read_pend_r = 1'h0;
      st_nxt.emerge_r    = 1'h0;
      st_nxt.drive_r     = st.read_pend_r;
      if (st.read_pend_r)
      begin
         st_nxt.dout_r = {mif.rpar, mif.rdata};
      end
      mif.addr  = st.addr_r;
      mif.re    = 1'h0;
      mif.we    = LANES_NONE;
      mif.wdata = data_in;
      mif.wpar  = parity_pins_in;

      case (st.state)
         PSS_SLEEP:
         begin
            st_nxt.drive_r = 1'h0;
            if (awake)
            begin
               st_nxt.state = PSS_IDLE;
            end
         end
         PSS_IDLE, PSS_BURST:
         begin
            if (!awake)
            begin
               st_nxt.state   = PSS_SLEEP;
               st_nxt.drive_r = 1'h0;
            end
            else if (load_c && sel_c)
            begin
               st_nxt.addr_r   = addr_in;
               st_nxt.start_r  = addr_in[BURST_W-1:0];
               st_nxt.cnt_r    = BURST_FIRST;
               st_nxt.state    = PSS_BURST;
               st_nxt.emerge_r = (st.state == PSS_IDLE);
               mif.addr        = addr_in;
               if (ctrl_acc && (lanes_c != LANES_NONE))
               begin
                  mif.we         = lanes_c;
                  st_nxt.drive_r = 1'h0;
               end
               else
               begin
                  mif.re             = 1'h1;
                  st_nxt.read_pend_r = 1'h1;
               end
            end
            else if (load_c)
            begin
               st_nxt.state   = PSS_IDLE;
               st_nxt.drive_r = 1'h0;
            end
            else if (st.state == PSS_BURST)
            begin
               if (~burst_step_n_in)
               begin
                  st_nxt.cnt_r = BURST_W'(st.cnt_r + BURST_ONE);
               end
               mif.addr = {st.addr_r[ADDR_W-1:BURST_W], burst_low(st.start_r, st_nxt.cnt_r, st.mode_s2)};
               if (lanes_c != LANES_NONE)
               begin
                  mif.we         = lanes_c;
                  st_nxt.drive_r = 1'h0;
               end
               else
               begin
                  mif.re             = 1'h1;
                  st_nxt.read_pend_r = 1'h1;
               end
            end
         end
         default:
         begin
            st_nxt = ST_RESET;
         end
      endcase
      // A deselect or a write in this cycle is allowed to hold back a pending read result.
      release_c = (load_c && !sel_c) || (mif.we != LANES_NONE);
   end

   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         st <= ST_RESET;
      end
      else
      begin
         st <= st_nxt;
      end
   end

   // asynchronous enable; writes also release the pins.
   assign data_oe_n_out   = ~(st.drive_r & ~st.emerge_r & ~output_enable_n_in & (mif.we == LANES_NONE));
   assign parity_oe_n_out = data_oe_n_out;
   assign data_out        = st.dout_r[DATA_W-1:0];
   assign parity_pins_out = st.dout_r[DATA_W+PAR_W-1:DATA_W];
   assign sleeping_out    = (st.state == PSS_SLEEP);

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   property p_deselect_release;
      (load_c && !sel_c) |=> data_oe_n_out;
   endproperty
   a_deselect_release: assert property (p_deselect_release) else $error("outputs driven after deselect");

   property p_cpu_ignored;
      (!cpu_addr_strobe_n_in && select_low_first_n_in && ctrl_addr_strobe_n_in && st.state == PSS_IDLE && awake)
      |=> st.state == PSS_IDLE;
   endproperty
   a_cpu_ignored: assert property (p_cpu_ignored) else $error("processor strobe taken with first select high");

   property p_addr_load;
      (load_c && sel_c && awake) |=> (st.addr_r == $past(addr_in) && st.cnt_r == BURST_FIRST);
   endproperty
   a_addr_load: assert property (p_addr_load) else $error("address not captured on strobe");

   property p_read_latency;
      (mif.re ##1 awake) |=> ((st.drive_r || $past(release_c)) &&
                              parity_pins_out == $past(mif.rpar) && data_out == $past(mif.rdata));
   endproperty
   a_read_latency: assert property (p_read_latency) else $error("read data not one stage behind address");

   property p_emerge_mask;
      (load_c && sel_c && st.state == PSS_IDLE) |=> data_oe_n_out;
   endproperty
   a_emerge_mask: assert property (p_emerge_mask) else $error("pins driven in first cycle after deselect");

   property p_oe_release;
      output_enable_n_in |-> (data_oe_n_out && parity_oe_n_out);
   endproperty
   a_oe_release: assert property (p_oe_release) else $error("pins driven with output enable high");

   property p_burst_step;
      (st.state == PSS_BURST && !load_c && awake && !burst_step_n_in) |=> st.cnt_r == $past(st.cnt_r) + BURST_ONE;
   endproperty
   a_burst_step: assert property (p_burst_step) else $error("burst counter did not advance");

   property p_cpu_wins;
      (!cpu_addr_strobe_n_in && !ctrl_addr_strobe_n_in && !select_low_first_n_in && awake) |-> mif.we == LANES_NONE;
   endproperty
   a_cpu_wins: assert property (p_cpu_wins) else $error("controller strobe honoured over processor strobe");

   property p_global_write;
      (st.state == PSS_BURST && !load_c && awake && !write_all_bytes_n_in) |-> mif.we == LANES_ALL;
   endproperty
   a_global_write: assert property (p_global_write) else $error("global write missed a lane");

   property p_selects_ignored;
      (st.state == PSS_BURST && !load_c && awake) |=> st.state == PSS_BURST;
   endproperty
   a_selects_ignored: assert property (p_selects_ignored) else $error("burst ended without a new address");

   c_read_burst: cover property (mif.re ##1 (mif.re && !load_c) ##1 mif.re);
   c_deselect: cover property (load_c && !sel_c);
   c_sleep: cover property (st.state == PSS_SLEEP ##1 st.state == PSS_IDLE);
endmodule : pss_sram_port

/* File: rtl/pss_pkg.sv */
// Purpose: Shared constants and types of the pipelined synchronous SRAM port.
// Assumes: The x36 organisation: 20 address bits, four lanes of eight data bits and one parity bit.
// Notes:   The array is split per lane so that byte writes never touch a neighbouring lane.
package pss_pkg;
   localparam int ADDR_W  = 20;
   localparam int DATA_W  = 32;
   localparam int PAR_W   = 4;
   localparam int LANES   = 4;
   localparam int LANE_W  = 8;
   localparam int BURST_W = 2;
   localparam int DEPTH   = 1 << ADDR_W;

   // Strap level that selects linear burst order; the other level selects interleaved.
   localparam logic MODE_LINEAR = 1'h0;

   localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
   localparam logic [BURST_W-1:0] BURST_ONE   = 2'h1;
   localparam logic [LANES-1:0]   LANES_NONE  = 4'h0;
   localparam logic [LANES-1:0]   LANES_ALL   = 4'hF;

   typedef enum logic [2:0]
   {
      PSS_IDLE  = 3'h1,
      PSS_BURST = 3'h2,
      PSS_SLEEP = 3'h4
   } pss_state_t;
endpackage : pss_pkg

/* File: rtl/pss_mem_if.sv */
// Purpose: Carries one array access per clock between the port logic and the array.
// Assumes: Read data appear one clock after the access that asked for them.
// Notes:   Lane i holds data bits 8i+7..8i and parity bit i.
`timescale 1ns/10ps
interface pss_mem_if;
   logic [pss_pkg::ADDR_W-1:0] addr;
   logic                       re;
   logic [pss_pkg::LANES-1:0]  we;
   logic [pss_pkg::DATA_W-1:0] wdata;
   logic [pss_pkg::PAR_W-1:0]  wpar;
   logic [pss_pkg::DATA_W-1:0] rdata;
   logic [pss_pkg::PAR_W-1:0]  rpar;

   modport ctl (output addr, re, we, wdata, wpar, input rdata, rpar);
   modport mem (input addr, re, we, wdata, wpar, output rdata, rpar);
endinterface : pss_mem_if

/* File: rtl/pss_mem_array.sv */
// Purpose: Storage array with per-lane write enables and a registered read port.
// Assumes: One access per clock; a read and a write are never asked for together.
// Notes:   Contents are not cleared by reset, as a real array is not.
`timescale 1ns/10ps
module pss_mem_array
(
   input  wire logic clk_in,
   pss_mem_if.mem    mif
);
   import pss_pkg::*;

   genvar lane;
   generate
      for (lane = 0; lane < LANES; lane++)
      begin : g_lane
         logic [LANE_W:0] lane_mem_r [0:DEPTH-1];
         logic [LANE_W:0] rd_r;

         always_ff @(posedge clk_in)
         begin
            if (mif.we[lane])
            begin
               lane_mem_r[mif.addr] <= {mif.wpar[lane], mif.wdata[lane*LANE_W +: LANE_W]};
            end
            if (mif.re)
            begin
               rd_r <= lane_mem_r[mif.addr];
            end
         end

         assign mif.rdata[lane*LANE_W +: LANE_W] = rd_r[LANE_W-1:0];
         assign mif.rpar[lane]                   = rd_r[LANE_W];
      end
   endgenerate
endmodule : pss_mem_array

/* File: dv/pss_bus_partner.sv */
// Purpose: Host-side model of the shared data and parity wires.
// Assumes: The host drives only while the device has released the pins.
// Notes:   A released wire toggles every clock because it has no pull, so a stale value never reads back.
`timescale 1ns/10ps
module pss_bus_partner
(
   input  wire logic        clk_in,
   input  wire logic        host_drv_in,
   input  wire logic [35:0] host_val_in,
   input  wire logic [35:0] dev_val_in,
   input  wire logic        dev_oe_n_in,
   output wire logic [35:0] pin_out
);
   logic [35:0] last_r = 36'h0;
   assign pin_out = !dev_oe_n_in ? dev_val_in : host_drv_in ? host_val_in : ~last_r;
   always_ff @(posedge clk_in)
   begin
      last_r <= pin_out;
   end
endmodule : pss_bus_partner

/* File: dv/tb_top.sv */
// Purpose: Self-checking bench of the pipelined synchronous SRAM port.
// Assumes: Inputs change by non-blocking assignment at the rising edge; outputs are read at the falling edge.
// Notes:   The third select follows the first, so it is never tested on its own.
`timescale 1ns/10ps
module tb_top;
   import pss_pkg::*;
   localparam logic [ADDR_W-1:0] BASE = 20'hABC40;
   logic              clk_in   = 1'b0;
   logic              reset_in = 1'b1;
   logic [ADDR_W-1:0] addr     = 20'h0;
   logic              cpu_n    = 1'b1;
   logic              ctrl_n   = 1'b1;
   logic              sel1_n   = 1'b1;
   logic              sel2     = 1'b0;
   logic              sel3_n   = 1'b1;
   logic              step_n   = 1'b1;
   logic              gw_n     = 1'b1;
   logic              gate_n   = 1'b1;
   logic [LANES-1:0]  lane_n   = 4'hF;
   logic              oe_n     = 1'b0;
   logic              sleep    = 1'b0;
   logic              order    = 1'b0;
   logic              drv      = 1'b0;
   logic [35:0]       hval     = 36'h0;
   wire  [35:0]       pin;
   wire  [DATA_W-1:0] dout;
   wire  [PAR_W-1:0]  pout;
   wire               doe_n;
   wire               slp;
   logic [35:0]       exp_m [0:3];
   int                err_total = 0;
   int                checks    = 0;

   always #5 clk_in = ~clk_in;

   pss_sram_port u_dut (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr), .cpu_addr_strobe_n_in(cpu_n),
      .ctrl_addr_strobe_n_in(ctrl_n), .select_low_first_n_in(sel1_n), .select_high_second_in(sel2),
      .select_low_third_n_in(sel3_n), .burst_step_n_in(step_n), .write_all_bytes_n_in(gw_n),
      .byte_write_gate_n_in(gate_n), .byte_lane_sel_n_in(lane_n), .output_enable_n_in(oe_n),
      .sleep_request_in(sleep), .burst_order_in(order), .data_in(pin[31:0]), .parity_pins_in(pin[35:32]),
      .data_out(dout), .data_oe_n_out(doe_n), .parity_pins_out(pout), .parity_oe_n_out(), .sleeping_out(slp));

   pss_bus_partner u_host (.clk_in(clk_in), .host_drv_in(drv), .host_val_in(hval), .dev_val_in({pout, dout}),
      .dev_oe_n_in(doe_n), .pin_out(pin));

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : stop_test

   task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH %s exp %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic ctl(input logic c, input logic k, input logic s1, input logic s2, input logic st,
                      input logic g, input logic gt, input logic [3:0] ln);
      cpu_n  <= c;
      ctrl_n <= k;
      sel1_n <= s1;
      sel3_n <= s1;
      sel2   <= s2;
      step_n <= st;
      gw_n   <= g;
      gate_n <= gt;
      lane_n <= ln;
   endtask : ctl

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [35:0] v, input logic g, input logic gt,
                     input logic [3:0] ln);
      @(posedge clk_in);
      addr <= a;
      oe_n <= 1'b1;
      drv  <= 1'b1;
      hval <= v;
      ctl(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, g, gt, ln);
      @(posedge clk_in);
      drv  <= 1'b0;
      oe_n <= 1'b0;
      ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, LANES_ALL);
   endtask : wr

   // Processor-strobe write: the load edge is a read, the global write lands on the next edge.
   task automatic wr_cpu(input logic [ADDR_W-1:0] a, input logic [35:0] v);
      @(posedge clk_in);
      addr <= a;
      oe_n <= 1'b1;
      drv  <= 1'b1;
      hval <= v;
      ctl(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, LANES_ALL);
      @(posedge clk_in);
      ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, LANES_ALL);
      @(posedge clk_in);
      drv  <= 1'b0;
      oe_n <= 1'b0;
      ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, LANES_ALL);
   endtask : wr_cpu

   // Burst of four from a start offset; both asks for a write-flavoured controller strobe beside the processor one.
   task automatic rd(input logic [1:0] st, input logic ilv, input logic both);
      logic [1:0] ix;
      // Deselect first so that the strobe below emerges from the deselected state.
      @(posedge clk_in);
      ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, LANES_ALL);
      @(posedge clk_in);
      addr <= BASE | ADDR_W'(st);
      ctl(1'b0, !both, 1'b0, 1'b1, 1'b1, !both, 1'b1, LANES_ALL);
      @(posedge clk_in);
      ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, LANES_ALL);
      @(negedge clk_in);
      chk("first cycle oe", doe_n, 36'h1);
      for (int k = 0; k < 4; k++)
      begin
         @(posedge clk_in);
         if (k == 2)
            step_n <= 1'b1;
         @(negedge clk_in);
         ix = ilv ? (st ^ 2'(k)) : (st + 2'(k));
         chk("read oe", doe_n, 36'h0);
         chk("burst data", {pout, dout}, exp_m[ix]);
      end
      $display("burst read done start %0d order %0d", st, ilv);
   endtask : rd

   task automatic desel();
      @(posedge clk_in);
      ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, LANES_ALL);
      @(posedge clk_in);
      ctl(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, LANES_ALL);
      @(negedge clk_in);
      chk("deselect oe", doe_n, 36'h1);
      @(posedge clk_in);
      ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, LANES_ALL);
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      chk("ignored strobe oe", doe_n, 36'h1);
      $display("deselect done");
   endtask : desel

   task automatic wait_slp(input logic v);
      int n;
      n = 0;
      while (slp !== v)
      begin
         @(negedge clk_in);
         n++;
         if (n > 8)
         begin
            err_total++;
            stop_test();
         end
      end
      chk("sleep status", slp, 36'(v));
   endtask : wait_slp

   task automatic nap();
      @(posedge clk_in);
      sleep <= 1'b1;
      wait_slp(1'b1);
      @(posedge clk_in);
      ctl(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, LANES_ALL);
      @(posedge clk_in);
      ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, LANES_ALL);
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      chk("asleep oe", doe_n, 36'h1);
      @(posedge clk_in);
      sleep <= 1'b0;
      wait_slp(1'b0);
      $display("sleep done");
   endtask : nap

   initial
   begin
      repeat (6) @(posedge clk_in);
      reset_in <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         exp_m[i] = 36'h9_A5C3_1E00 + 36'(i) * 36'h1_0101_0101;
         wr(BASE | ADDR_W'(i), exp_m[i], 1'b0, 1'b1, LANES_ALL);
      end
      // Lanes 0 and 2 selected, lanes 1 and 3 must keep their old bytes.
      wr(BASE | 20'h1, 36'hF_FFFF_FFFF, 1'b1, 1'b0, 4'hA);
      exp_m[1] = (exp_m[1] & 36'hA_FF00_FF00) | 36'h5_00FF_00FF;
      exp_m[3] = 36'h3_C3C3_3C3C;
      wr_cpu(BASE | 20'h3, exp_m[3]);
      rd(2'h1, 1'b0, 1'b0);
      @(posedge clk_in);
      order <= 1'b1;
      repeat (3) @(posedge clk_in);
      rd(2'h1, 1'b1, 1'b0);
      rd(2'h2, 1'b1, 1'b1);
      desel();
      nap();
      rd(2'h3, 1'b1, 1'b0);
      stop_test();
   end
endmodule : tb_top
